// >>> logic/sysreg_file.sv
`timescale 1ns/1ps
`include "sysreg_params.svh"
// Summary of operation
// RQ1: A load move writes the whole general register word into the numbered system register.
// RQ2: A store move returns the numbered system register word to a general register.
// RQ3: Numbers 6-15 and 21-31 are reserved and refused for both load and store.
// RQ4: Number 4 holds the interrupt source code, readable by store, never written by load.
// RQ5: Numbers 0 and 1 save PC and status on a maskable interrupt and are read/write.
// RQ6: Numbers 2 and 3 save PC and status on a non-maskable interrupt and are read/write.
// RQ7: Number 5 is the status word and may be loaded and stored.
// RQ8: Numbers 16 and 17 save PC and status on a table call, only on enhanced cores.
// RQ9: Numbers 18 and 19 save PC and status on an exception or debug trap, read/write.
// RQ10: Number 20 holds the table-call base address, loadable and storable; the code refuses both moves to it on cores built with ENHANCED off.
// RQ11: Every implemented system register is 32 bits wide.
module sysreg_file #(
    parameter int          WIDTH    = 32,                                        // [RQ11]
    parameter bit          ENHANCED = 1'b1
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_nrst,
    input  sysreg_pkg::sr_req_t        i_req,
    input  sysreg_pkg::sr_event_t      i_event,
    input  wire logic [WIDTH-1:0]      i_event_pc,
    input  wire logic [WIDTH-1:0]      i_event_cause,
    input  wire logic [WIDTH-1:0]      i_psw_update,
    input  wire logic                  i_psw_update_en,
    output sysreg_pkg::sr_rsp_t        o_rsp,
    output logic [WIDTH-1:0]           o_psw,
    output logic [WIDTH-1:0]           o_table_call_base
);
    import sysreg_pkg::*;

    // ==========================================================
    // Storage
    logic [WIDTH-1:0] regs_q [`SR_COUNT];
    sr_access_t       acc;
    logic             wr_ok;
    logic             rd_ok;
    logic [4:0]       save_pc_num;
    logic [4:0]       save_st_num;
    logic             save_en;

    sysreg_access u_access (
        .i_num      (i_req.num),
        .i_enhanced (ENHANCED),
        .o_access   (acc)
    );

    // Permission checks for the two moves
    assign wr_ok = i_req.valid && i_req.is_load && (acc == ACC_RW);           // [RQ3] [RQ4]
    assign rd_ok = i_req.valid && !i_req.is_load && (acc != ACC_NONE);        // [RQ3]

    // ==========================================================
    // Save targets for hardware events
    always_comb begin
        save_en     = 1'b1;
        save_pc_num = `SR_IRQ_RETURN_PC;
        save_st_num = `SR_IRQ_SAVED_STATUS;
        case (i_event)
            EV_IRQ: begin                                                      // [RQ5]
                save_pc_num = `SR_IRQ_RETURN_PC;
                save_st_num = `SR_IRQ_SAVED_STATUS;
            end
            EV_NMI: begin                                                      // [RQ6]
                save_pc_num = `SR_NMI_RETURN_PC;
                save_st_num = `SR_NMI_SAVED_STATUS;
            end
            EV_TABLE_CALL: begin                                               // [RQ8]
                save_en     = ENHANCED;
                save_pc_num = `SR_TABLE_CALL_RETURN_PC;
                save_st_num = `SR_TABLE_CALL_SAVED_STATUS;
            end
            EV_TRAP: begin                                                     // [RQ9]
                save_pc_num = `SR_TRAP_RETURN_PC;
                save_st_num = `SR_TRAP_SAVED_STATUS;
            end
            default: save_en = 1'b0;
        endcase
    end

    // ==========================================================
    // Register writes; hardware saves win over a software load
    // to the same number, as the event must not be lost
    genvar g;
    generate
        for (g = 0; g < `SR_COUNT; g++) begin : g_reg
            always_ff @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    regs_q[g] <= `SR_RESET_VALUE;
                end else if (save_en && save_pc_num == 5'(g)) begin
                    regs_q[g] <= i_event_pc;
                end else if (save_en && save_st_num == 5'(g)) begin
                    regs_q[g] <= regs_q[`SR_PROGRAM_STATUS_WORD];
                end else if (i_event != EV_NONE
                             && 5'(g) == `SR_INTERRUPT_SOURCE_CODE) begin
                    regs_q[g] <= i_event_cause;                                // [RQ4]
                end else if (i_psw_update_en && 5'(g) == `SR_PROGRAM_STATUS_WORD) begin
                    regs_q[g] <= i_psw_update;
                end else if (wr_ok && i_req.num == 5'(g)) begin
                    regs_q[g] <= i_req.wdata;                                  // [RQ1] [RQ7] [RQ10]
                end
            end
        end
    endgenerate

    // ==========================================================
    // Move answer, one cycle after the request
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rsp <= '0;
        end else begin
            o_rsp.done   <= i_req.valid;
            o_rsp.denied <= i_req.valid && !(wr_ok || rd_ok);
            o_rsp.rdata  <= rd_ok ? regs_q[i_req.num] : '0;                    // [RQ2]
        end
    end

    // Live copies for the pipeline
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_psw             <= `SR_RESET_VALUE;
            o_table_call_base <= `SR_RESET_VALUE;
        end else begin
            o_psw             <= regs_q[`SR_PROGRAM_STATUS_WORD];              // [RQ7]
            o_table_call_base <= regs_q[`SR_TABLE_CALL_BASE];                  // [RQ10]
        end
    end
endmodule : sysreg_file

// >>> logic/sysreg_params.svh
`ifndef SYSREG_PARAMS_SVH
`define SYSREG_PARAMS_SVH
// ==========================================================
// Register numbers
`define SR_IRQ_RETURN_PC           5'h00
`define SR_IRQ_SAVED_STATUS        5'h01
`define SR_NMI_RETURN_PC           5'h02
`define SR_NMI_SAVED_STATUS        5'h03
`define SR_INTERRUPT_SOURCE_CODE   5'h04
`define SR_PROGRAM_STATUS_WORD     5'h05
`define SR_TABLE_CALL_RETURN_PC    5'h10
`define SR_TABLE_CALL_SAVED_STATUS 5'h11
`define SR_TRAP_RETURN_PC          5'h12
`define SR_TRAP_SAVED_STATUS       5'h13
`define SR_TABLE_CALL_BASE         5'h14
// ==========================================================
// Reset values and table size
`define SR_RESET_VALUE             32'h00000000
`define SR_COUNT                   32
`endif

// >>> logic/sysreg_pkg.sv
package sysreg_pkg;
    // Move request from the pipeline
    typedef struct packed {
        logic        valid;
        logic        is_load;   // 1: load into system reg, 0: store out
        logic [4:0]  num;
        logic [31:0] wdata;
    } sr_req_t;
    // Answer of a move
    typedef struct packed {
        logic        done;
        logic        denied;
        logic [31:0] rdata;
    } sr_rsp_t;
    // Hardware save events
    typedef enum logic [2:0] {
        EV_NONE, EV_IRQ, EV_NMI, EV_TABLE_CALL, EV_TRAP
    } sr_event_t;
    typedef enum logic [1:0] {
        ACC_NONE, ACC_RO, ACC_RW
    } sr_access_t;
endpackage : sysreg_pkg

// >>> logic/sysreg_access.sv
`timescale 1ns/1ps
`include "sysreg_params.svh"
// ==========================================================
// Permission decode per register number
module sysreg_access (
    input  wire logic [4:0]            i_num,
    input  wire logic                  i_enhanced,
    output sysreg_pkg::sr_access_t     o_access
);
    import sysreg_pkg::*;
    // Reserved and absent numbers give no access
    always_comb begin
        case (i_num)
            `SR_IRQ_RETURN_PC, `SR_IRQ_SAVED_STATUS,
            `SR_NMI_RETURN_PC, `SR_NMI_SAVED_STATUS,
            `SR_PROGRAM_STATUS_WORD:      o_access = ACC_RW;
            `SR_INTERRUPT_SOURCE_CODE:    o_access = ACC_RO;                   // [RQ4]
            `SR_TABLE_CALL_RETURN_PC, `SR_TABLE_CALL_SAVED_STATUS,
            `SR_TABLE_CALL_BASE:          o_access = i_enhanced ? ACC_RW : ACC_NONE; // [RQ8]
            `SR_TRAP_RETURN_PC, `SR_TRAP_SAVED_STATUS: o_access = ACC_RW;       // [RQ9]
            default:                      o_access = ACC_NONE;                 // [RQ3]
        endcase
    end
endmodule : sysreg_access

// >>> dv/sysreg_file_sva.sv
`timescale 1ns/1ps
// ==========
// Move answers and register contents
module sysreg_file_sva #(parameter int WIDTH = 32, parameter bit ENHANCED = 1'b1) (
    input wire logic             i_clk_sys,
    input wire logic             i_nrst,
    input sysreg_pkg::sr_req_t   i_req,
    input sysreg_pkg::sr_event_t i_event,
    input wire logic [WIDTH-1:0] i_event_pc,
    input wire logic             i_psw_update_en,
    input sysreg_pkg::sr_rsp_t   o_rsp,
    input wire logic [WIDTH-1:0] o_psw,
    input wire logic [WIDTH-1:0] o_table_call_base
);
    import sysreg_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // Load and store strobes
    wire logic ld = i_req.valid && i_req.is_load;
    wire logic st = i_req.valid && !i_req.is_load;
    done_one_a: assert property (i_req.valid |=> o_rsp.done)
        else $error("move not answered");
    no_spur_a: assert property (!i_req.valid |=> !o_rsp.done)
        else $error("answer without move");
    resv_deny_a: assert property (i_req.valid && i_req.num inside {[6:15], [21:31]}
        |=> o_rsp.denied && o_rsp.rdata == 0) else $error("reserved number served");
    ro_load_a: assert property (ld && i_req.num == 5'h04 |=> o_rsp.denied)
        else $error("cause register loaded");
    // Same-number store right after a clean load returns the word
    rw_back_a: assert property (ld && !(i_req.num inside {[4:15], [21:31]})
        && (ENHANCED || !(i_req.num inside {[16:17], 20}))
        && i_event == EV_NONE && !i_psw_update_en ##1 st && i_req.num == $past(i_req.num)
        |=> !o_rsp.denied && o_rsp.rdata == $past(i_req.wdata, 2)) else $error("readback");
    psw_load_a: assert property (ld && i_req.num == 5'h05 && i_event == EV_NONE
        && !i_psw_update_en |=> ##1 o_psw == $past(i_req.wdata, 2)) else $error("status");
    base_load_a: assert property (ENHANCED && ld && i_req.num == 5'h14
        ##1 !(ld && i_req.num == 5'h14)
        |=> o_table_call_base == $past(i_req.wdata, 2)) else $error("base pointer");
    irq_save_a: assert property (i_event == EV_IRQ ##1 st && i_req.num == 5'h00
        |=> o_rsp.rdata == $past(i_event_pc, 2)) else $error("saved pc");
endmodule : sysreg_file_sva
bind sysreg_file sysreg_file_sva #(.WIDTH(WIDTH), .ENHANCED(ENHANCED)) u_sva (.i_clk_sys,
    .i_nrst, .i_req,
    .i_event, .i_event_pc, .i_psw_update_en, .o_rsp, .o_psw, .o_table_call_base);

// >>> dv/pipe_model.sv
`timescale 1ns/1ps
// ==========
// Pipeline side, issues moves off the falling edge
module pipe_model (
    input  wire logic          i_clk_sys,
    output sysreg_pkg::sr_req_t o_req
);
    import sysreg_pkg::*;
    // One move a call; two calls in a row go back to back
    task automatic issue(input logic ld, input logic [4:0] n, input logic [31:0] d);
        @(negedge i_clk_sys);
        o_req <= '{1'b1, ld, n, d};
    endtask : issue
    // Released fields inverted so a stale word never passes
    task automatic idle();
        @(negedge i_clk_sys);
        o_req <= '{1'b0, 1'b0, ~o_req.num, ~o_req.wdata};
    endtask : idle
    initial o_req = '0;
endmodule : pipe_model

// >>> dv/cpu_system_register_file_tb.sv
`timescale 1ns/1ps
module cpu_system_register_file_tb;
    import sysreg_pkg::*;
    typedef struct packed {logic ld; logic [4:0] n; logic [31:0] d; logic dn; logic [31:0] q;} row_t;
    logic        i_clk_sys, i_nrst, i_psw_update_en;
    logic [31:0] i_event_pc, i_event_cause, i_psw_update, o_psw, o_table_call_base;
    sr_req_t     i_req;
    sr_event_t   i_event;
    sr_rsp_t     o_rsp;
    sr_rsp_t     o_rsp_b;
    logic [31:0] o_psw_b, o_tcb_b;
    int          n_fail, cmp_count, cyc;
    logic [4:0]  pcn [4] = '{5'h00, 5'h02, 5'h10, 5'h12};
    sr_event_t   evs [4] = '{EV_IRQ, EV_NMI, EV_TABLE_CALL, EV_TRAP};
    // Ordinary moves beside their answers
    row_t rows [10] = '{'{1, 5'h00, 32'hA0, 0, 0}, '{0, 5'h00, 0, 0, 32'hA0},
        '{1, 5'h04, 32'h1, 1, 0}, '{0, 5'h04, 0, 0, 0}, '{1, 5'h14, 32'hC0, 0, 0},
        '{0, 5'h14, 0, 0, 32'hC0}, '{1, 5'h06, 32'h2, 1, 0}, '{0, 5'h0F, 0, 1, 0},
        '{0, 5'h15, 0, 1, 0}, '{1, 5'h1F, 32'h3, 1, 0}};
    sysreg_file DUT (.i_clk_sys, .i_nrst, .i_req, .i_event, .i_event_pc, .i_event_cause,
        .i_psw_update, .i_psw_update_en, .o_rsp, .o_psw, .o_table_call_base);
    // Original-core build: table-call registers absent
    sysreg_file #(.ENHANCED(1'b0)) DUT_BASE (.i_clk_sys, .i_nrst, .i_req, .i_event,
        .i_event_pc, .i_event_cause, .i_psw_update, .i_psw_update_en, .o_rsp(o_rsp_b),
        .o_psw(o_psw_b), .o_table_call_base(o_tcb_b));
    pipe_model u_pm (.i_clk_sys, .o_req(i_req));
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask : chk
    // One move, answer looked at while it stands
    task automatic op(input row_t r);
        u_pm.issue(r.ld, r.n, r.d);
        u_pm.idle();
        chk(1, o_rsp.done);
        chk(r.dn, o_rsp.denied);
        chk(r.dn || (r.n inside {5'h10, 5'h11, 5'h14}), o_rsp_b.denied);
        if (!r.ld || r.dn) chk(r.q, o_rsp.rdata);
    endtask : op
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // Clock, and a ceiling well past the seventy or so cycles needed
    initial begin
        i_clk_sys = 0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        {i_nrst, i_psw_update_en, i_event_pc, i_event_cause, i_psw_update} = '0;
        i_event = EV_NONE;
        repeat (6) @(negedge i_clk_sys);
        i_nrst = 1;
        foreach (rows[i]) op(rows[i]);
        $display("table done");
        u_pm.issue(1, 5'h05, 32'h5A05);
        u_pm.issue(0, 5'h05, 0);
        u_pm.idle();
        chk(32'h5A05, o_rsp.rdata);
        chk(32'h5A05, o_psw);
        $display("back to back done");
        for (int k = 0; k < 4; k++) begin
            @(negedge i_clk_sys);
            {i_event, i_event_pc, i_event_cause} <= {evs[k], 32'h8000 + k, 32'hA00 + k};
            @(negedge i_clk_sys);
            i_event <= EV_NONE;
            op('{0, pcn[k], 0, 0, 32'h8000 + k});
            op('{0, pcn[k] + 5'h01, 0, 0, 32'h5A05});
            op('{0, 5'h04, 0, 0, 32'hA00 + k});
        end
        $display("events done");
        @(negedge i_clk_sys);
        {i_psw_update, i_psw_update_en} <= {32'h77, 1'b1};
        @(negedge i_clk_sys);
        i_psw_update_en <= 0;
        @(negedge i_clk_sys);
        chk(32'h77, o_psw);
        i_nrst <= 0;
        @(negedge i_clk_sys);
        chk(0, o_psw);
        i_nrst <= 1;
        op('{0, 5'h00, 0, 0, 0});
        $display("update and reset done");
        test_done();
    end
endmodule : cpu_system_register_file_tb
